// file: include/gpt_pkg.sv
// Package with register map, field layout and timing counts of the timer block
package gpt_pkg;

  localparam logic [7:0] OFF_SA_CTRL = 8'h00;
  localparam logic [7:0] OFF_SA_COUNT = 8'h04;
  localparam logic [7:0] OFF_SA_PERIOD = 8'h08;
  localparam logic [7:0] OFF_PAIR_CTRL = 8'h0c;
  localparam logic [7:0] OFF_PAIR_UPPER_CTRL = 8'h10;
  localparam logic [7:0] OFF_PAIR_LOW_COUNT = 8'h14;
  localparam logic [7:0] OFF_PAIR_HIGH_COUNT = 8'h18;
  localparam logic [7:0] OFF_PAIR_LOW_PERIOD = 8'h1c;
  localparam logic [7:0] OFF_PAIR_HIGH_PERIOD = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;

  localparam int BIT_TIMER_ON = 15;
  localparam int BIT_STOP_IN_IDLE = 13;
  localparam int BIT_GATED = 6;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_JOIN_32BIT = 3;
  localparam int BIT_EXT_SYNC = 2;
  localparam int BIT_CLOCK_SOURCE = 1;

  localparam logic [15:0] MASK_SA_CTRL = 16'ha076;
  localparam logic [15:0] MASK_PAIR_CTRL = 16'ha07a;
  localparam logic [15:0] MASK_PAIR_UPPER_CTRL = 16'ha072;

  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hffff;

  localparam int STAT_SA = 0;
  localparam int STAT_PAIR_LOW = 1;
  localparam int STAT_PAIR_HIGH = 2;

  localparam logic [7:0] PRE_LIMIT_1 = 8'h00;
  localparam logic [7:0] PRE_LIMIT_8 = 8'h07;
  localparam logic [7:0] PRE_LIMIT_64 = 8'h3f;
  localparam logic [7:0] PRE_LIMIT_256 = 8'hff;

  typedef struct packed {
    logic timer_on;
    logic stop_in_idle;
    logic gated_accumulation_enable;
    logic [1:0] prescale_select;
    logic join_32bit_select;
    logic external_clock_sync;
    logic clock_source_select;
  } gpt_ctrl_t;

  function automatic gpt_ctrl_t gpt_decode(input logic [15:0] r);
    gpt_ctrl_t c;
    c.timer_on = r[BIT_TIMER_ON];
    c.stop_in_idle = r[BIT_STOP_IN_IDLE];
    c.gated_accumulation_enable = r[BIT_GATED];
    c.prescale_select = r[BIT_PRESCALE_LO +: 2];
    c.join_32bit_select = r[BIT_JOIN_32BIT];
    c.external_clock_sync = r[BIT_EXT_SYNC];
    c.clock_source_select = r[BIT_CLOCK_SOURCE];
    return c;
  endfunction

endpackage

// file: logic/gpt_step_gen.sv
// Count step generator: source select, gating, prescaler, idle and sleep
`timescale 1ns/1ns
module gpt_step_gen
  import gpt_pkg::*;
#(
  parameter bit ASYNC_OK = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire gpt_ctrl_t cfg_i,
  input wire logic pin_i,
  input wire logic idle_i,
  input wire logic sleep_i,
  output logic step_o,
  output logic gate_fall_o
);

  logic pin_d_reg;
  logic [7:0] pre_cnt_reg;
  logic [7:0] pre_limit;
  logic rise;
  logic fall;
  logic async_run;
  logic run;
  logic src_tick;

  assign rise = pin_i & ~pin_d_reg;
  assign fall = ~pin_i & pin_d_reg;
  // Unsynchronised external counting keeps going in sleep
  assign async_run = ASYNC_OK & cfg_i.clock_source_select &
                     ~cfg_i.external_clock_sync;
  assign run = cfg_i.timer_on & ~(idle_i & cfg_i.stop_in_idle) &
               ~(sleep_i & ~async_run);
  // External rising edges, or internal clock gated by the pin level
  assign src_tick = cfg_i.clock_source_select ? rise :
                    (cfg_i.gated_accumulation_enable ? pin_i : 1'b1);

  always_comb begin
    unique case (cfg_i.prescale_select)
      2'b00: pre_limit = PRE_LIMIT_1;
      2'b01: pre_limit = PRE_LIMIT_8;
      2'b10: pre_limit = PRE_LIMIT_64;
      2'b11: pre_limit = PRE_LIMIT_256;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_d_reg <= 1'b0;
    end else begin
      pin_d_reg <= pin_i;
    end
  end

  // Prescaler divides the selected source
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt_reg <= 8'h00;
      step_o <= 1'b0;
    end else begin
      step_o <= 1'b0;
      if (!cfg_i.timer_on) begin
        pre_cnt_reg <= 8'h00;
      end else if (run && src_tick) begin
        if (pre_cnt_reg >= pre_limit) begin
          pre_cnt_reg <= 8'h00;
          step_o <= 1'b1;
        end else begin
          pre_cnt_reg <= pre_cnt_reg + 8'h01;
        end
      end
    end
  end

  // Falling gate edge event while gated accumulation runs
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gate_fall_o <= 1'b0;
    end else begin
      gate_fall_o <= cfg_i.timer_on & ~cfg_i.clock_source_select &
                     cfg_i.gated_accumulation_enable & fall;
    end
  end

endmodule

// file: logic/gpt_top.sv
// Timer block top: standalone timer, joinable timer pair and APB registers
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module gpt_top
  import gpt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic standalone_ext_clock_pin_i,
  input wire logic pair_ext_clock_pin_i,
  input wire logic pair_upper_ext_clock_pin_i,
  input wire logic idle_i,
  input wire logic sleep_i,
  output logic standalone_irq_o,
  output logic pair_low_irq_o,
  output logic pair_high_irq_o,
  output logic adc_trigger_o,
  output logic [15:0] pair_low_count_o,
  output logic [15:0] pair_high_count_o
);

  logic [15:0] standalone_timer_control_reg;
  logic [15:0] pair_timer_control_reg;
  logic [15:0] pair_upper_control_reg;
  logic [15:0] standalone_count_reg;
  logic [15:0] standalone_period_reg;
  logic [15:0] pair_low_count_reg;
  logic [15:0] pair_high_count_reg;
  logic [15:0] pair_low_period_reg;
  logic [15:0] pair_high_period_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pin_filt_reg;
  logic [31:0] rdata_next;
  logic addr_ok;

  gpt_ctrl_t sa_cfg;
  gpt_ctrl_t lo_cfg;
  gpt_ctrl_t hi_cfg;
  logic joined;
  logic sa_step;
  logic lo_step;
  logic hi_step;
  logic sa_fall;
  logic lo_fall;
  logic hi_fall;
  logic wr_en;
  logic rd_phase;
  logic sa_match;
  logic lo_match;
  logic hi_match;
  logic match32;
  logic sa_set;
  logic lo_set;
  logic hi_set;
  logic [31:0] count32;

  assign sa_cfg = gpt_decode(standalone_timer_control_reg);
  assign lo_cfg = gpt_decode(pair_timer_control_reg);
  assign hi_cfg = gpt_decode(pair_upper_control_reg);
  assign joined = lo_cfg.join_32bit_select;

  // Pins pass three flops; a change counts once stages two and three agree
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      pin_filt_reg <= 3'h0;
    end else begin
      sync1_reg <= {pair_upper_ext_clock_pin_i, pair_ext_clock_pin_i,
                    standalone_ext_clock_pin_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 3; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_filt_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // Standalone may count unsynchronised in sleep; pair timers stop in sleep
  gpt_step_gen #(
    .ASYNC_OK(1'b1)
  ) u_sa_step (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .cfg_i(sa_cfg),
    .pin_i(pin_filt_reg[0]),
    .idle_i(idle_i),
    .sleep_i(sleep_i),
    .step_o(sa_step),
    .gate_fall_o(sa_fall)
  );

  gpt_step_gen #(
    .ASYNC_OK(1'b0)
  ) u_lo_step (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .cfg_i(lo_cfg),
    .pin_i(pin_filt_reg[1]),
    .idle_i(idle_i),
    .sleep_i(sleep_i),
    .step_o(lo_step),
    .gate_fall_o(lo_fall)
  );

  gpt_step_gen #(
    .ASYNC_OK(1'b0)
  ) u_hi_step (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .cfg_i(hi_cfg),
    .pin_i(pin_filt_reg[2]),
    .idle_i(idle_i),
    .sleep_i(sleep_i),
    .step_o(hi_step),
    .gate_fall_o(hi_fall)
  );

  assign count32 = {pair_high_count_reg, pair_low_count_reg};
  assign match32 = count32 == {pair_high_period_reg, pair_low_period_reg};
  assign sa_match = standalone_count_reg == standalone_period_reg;
  assign lo_match = pair_low_count_reg == pair_low_period_reg;
  assign hi_match = pair_high_count_reg == pair_high_period_reg;

  // Flag events; joined mode reports on the high flag only
  assign sa_set = (sa_step & sa_match) | sa_fall;
  assign lo_set = ~joined & ((lo_step & lo_match) | lo_fall);
  assign hi_set = joined ? ((lo_step & match32) | lo_fall) :
                  ((hi_step & hi_match) | hi_fall);

  // APB: one wait state, write takes effect when pready is high, read data is sampled in the wait state
  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_phase = psel_i & penable_i & ~pready_o;

  always_comb begin
    addr_ok = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (paddr_i)
      OFF_SA_CTRL: rdata_next[15:0] = standalone_timer_control_reg;
      OFF_SA_COUNT: rdata_next[15:0] = standalone_count_reg;
      OFF_SA_PERIOD: rdata_next[15:0] = standalone_period_reg;
      OFF_PAIR_CTRL: rdata_next[15:0] = pair_timer_control_reg;
      OFF_PAIR_UPPER_CTRL: rdata_next[15:0] = pair_upper_control_reg;
      OFF_PAIR_LOW_COUNT: rdata_next[15:0] = pair_low_count_reg;
      OFF_PAIR_HIGH_COUNT: rdata_next[15:0] = pair_high_count_reg;
      OFF_PAIR_LOW_PERIOD: rdata_next[15:0] = pair_low_period_reg;
      OFF_PAIR_HIGH_PERIOD: rdata_next[15:0] = pair_high_period_reg;
      OFF_STATUS: rdata_next[2:0] = status_reg;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= rd_phase;
      pslverr_o <= rd_phase & ~addr_ok;
      if (rd_phase && !pwrite_i) begin
        prdata_o <= rdata_next;
      end
    end
  end

  // Control and period registers written by software
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      standalone_timer_control_reg <= RST_CTRL;
      pair_timer_control_reg <= RST_CTRL;
      pair_upper_control_reg <= RST_CTRL;
      standalone_period_reg <= RST_PERIOD;
      pair_low_period_reg <= RST_PERIOD;
      pair_high_period_reg <= RST_PERIOD;
    end else if (wr_en) begin
      unique case (paddr_i)
        OFF_SA_CTRL:
          standalone_timer_control_reg <= pwdata_i[15:0] & MASK_SA_CTRL;
        OFF_PAIR_CTRL:
          pair_timer_control_reg <= pwdata_i[15:0] & MASK_PAIR_CTRL;
        OFF_PAIR_UPPER_CTRL:
          pair_upper_control_reg <= pwdata_i[15:0] & MASK_PAIR_UPPER_CTRL;
        OFF_SA_PERIOD: standalone_period_reg <= pwdata_i[15:0];
        OFF_PAIR_LOW_PERIOD: pair_low_period_reg <= pwdata_i[15:0];
        OFF_PAIR_HIGH_PERIOD: pair_high_period_reg <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // Standalone count; writes blocked while running on external clock
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      standalone_count_reg <= RST_COUNT;
    end else if (wr_en && paddr_i == OFF_SA_COUNT &&
                 !(sa_cfg.timer_on && sa_cfg.clock_source_select)) begin
      standalone_count_reg <= pwdata_i[15:0];
    end else if (sa_step) begin
      standalone_count_reg <= sa_match ? 16'h0000 :
                              standalone_count_reg + 16'h0001;
    end
  end

  // Pair low word
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pair_low_count_reg <= RST_COUNT;
    end else if (wr_en && paddr_i == OFF_PAIR_LOW_COUNT) begin
      pair_low_count_reg <= pwdata_i[15:0];
    end else if (lo_step) begin
      if (joined ? match32 : lo_match) begin
        pair_low_count_reg <= 16'h0000;
      end else begin
        pair_low_count_reg <= pair_low_count_reg + 16'h0001;
      end
    end
  end

  // Pair high word: carries from the low word when joined
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pair_high_count_reg <= RST_COUNT;
    end else if (wr_en && paddr_i == OFF_PAIR_HIGH_COUNT) begin
      pair_high_count_reg <= pwdata_i[15:0];
    end else if (joined) begin
      if (lo_step && match32) begin
        pair_high_count_reg <= 16'h0000;
      end else if (lo_step && pair_low_count_reg == 16'hffff) begin
        pair_high_count_reg <= pair_high_count_reg + 16'h0001;
      end
    end else if (hi_step) begin
      pair_high_count_reg <= hi_match ? 16'h0000 :
                             pair_high_count_reg + 16'h0001;
    end
  end

  // Sticky flags, cleared by writing one; a new event wins over the clear
  always_comb begin
    status_next = status_reg;
    if (wr_en && paddr_i == OFF_STATUS) begin
      status_next = status_reg & ~pwdata_i[2:0];
    end
    status_next[STAT_SA] = status_next[STAT_SA] | sa_set;
    status_next[STAT_PAIR_LOW] = status_next[STAT_PAIR_LOW] | lo_set;
    status_next[STAT_PAIR_HIGH] = status_next[STAT_PAIR_HIGH] | hi_set;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= 3'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Event pulses and time base outputs
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      standalone_irq_o <= 1'b0;
      pair_low_irq_o <= 1'b0;
      pair_high_irq_o <= 1'b0;
      adc_trigger_o <= 1'b0;
      pair_low_count_o <= RST_COUNT;
      pair_high_count_o <= RST_COUNT;
    end else begin
      standalone_irq_o <= sa_set;
      pair_low_irq_o <= lo_set;
      pair_high_irq_o <= hi_set;
      adc_trigger_o <= joined & lo_step & match32;
      pair_low_count_o <= pair_low_count_reg;
      pair_high_count_o <= pair_high_count_reg;
    end
  end

endmodule

// file: test/gpt_chk.sv
// Port-level checker for the timer block, bound to its top module
`timescale 1ns/1ns
module gpt_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic standalone_irq_o,
  input wire logic pair_low_irq_o,
  input wire logic pair_high_irq_o,
  input wire logic adc_trigger_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  AST_PREADY_ONE: assert property (pready_o |=> !pready_o)
    else $error("pready held longer than one cycle");
  AST_PREADY_WAIT: assert property (
    $rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
    else $error("pready not in second access cycle");
  AST_ERR_READY: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (
    pready_o && paddr_i > 8'h24 |-> pslverr_o)
    else $error("unmapped access without error");
  AST_MAPPED: assert property (
    pready_o && paddr_i <= 8'h24 && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
    else $error("mapped access flagged as error");
  AST_UPPER_ZERO: assert property (
    pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_PRDATA_HOLD: assert property (
    $changed(prdata_o) |-> pready_o && !pwrite_i)
    else $error("read data changed outside a read");
  AST_ADC_NOT_LOW: assert property (adc_trigger_o |-> !pair_low_irq_o)
    else $error("joined match raised low flag");
  AST_ADC_WITH_HIGH: assert property (adc_trigger_o |-> pair_high_irq_o)
    else $error("joined match without high flag");

  cover property (standalone_irq_o);
  cover property (adc_trigger_o);
  cover property (pslverr_o);
endmodule

bind gpt_top gpt_chk gpt_chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .standalone_irq_o(standalone_irq_o),
  .pair_low_irq_o(pair_low_irq_o), .pair_high_irq_o(pair_high_irq_o),
  .adc_trigger_o(adc_trigger_o));

// file: test/tb.sv
// Self-checking testbench for the timer block
`timescale 1ns/1ns
module tb;
  import gpt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, idle = 1'b0, slp = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, v;
  logic [2:0] pin = 3'h0;
  logic pready, pslverr, sa_irq, pl_irq, ph_irq, adc;
  logic [15:0] lo_cnt, hi_cnt;
  logic [3:0] ev;
  int num_errors = 0, cmp_count = 0, n;
  localparam logic [7:0] CO [3] = '{OFF_SA_CTRL, OFF_PAIR_CTRL,
    OFF_PAIR_UPPER_CTRL};
  localparam logic [15:0] CM [3] = '{MASK_SA_CTRL, MASK_PAIR_CTRL,
    MASK_PAIR_UPPER_CTRL};
  localparam int DIV [4] = '{1, 8, 64, 256};
  localparam logic [15:0] EXT_CTRL [2] = '{16'h8006, 16'h8002};
  assign ev = {adc, ph_irq, pl_irq, sa_irq};
  always #5 clk_sys_i = ~clk_sys_i;

  gpt_top gpt_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .standalone_ext_clock_pin_i(pin[0]), .pair_ext_clock_pin_i(pin[1]),
    .pair_upper_ext_clock_pin_i(pin[2]), .idle_i(idle), .sleep_i(slp),
    .standalone_irq_o(sa_irq), .pair_low_irq_o(pl_irq),
    .pair_high_irq_o(ph_irq), .adc_trigger_o(adc),
    .pair_low_count_o(lo_cnt), .pair_high_count_o(hi_cnt));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    int cyc;
    cyc = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      cyc++;
    end while (pready !== 1'b1);
    chk("pready_cycles", 2, cyc);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 16'h0000);
    chk(nm, e, rdat);
  endtask

  // Cycles until the next pulse on event line s, -1 if none
  task automatic seek(input int s, input int lim, output int g);
    g = -1;
    for (int i = 1; i <= lim; i++) begin
      @(posedge clk_sys_i);
      if (ev[s] === 1'b1) begin
        g = i;
        break;
      end
    end
  endtask

  task automatic gap(input int s, input int lim, output int g);
    seek(s, lim, g);
    seek(s, lim, g);
  endtask

  task automatic edges(input int p, input int k);
    repeat (k) begin
      @(posedge clk_sys_i);
      pin[p] <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      pin[p] <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
    end
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic t_regs();
    rd(OFF_SA_CTRL, RST_CTRL, "sa_ctrl");
    rd(OFF_SA_PERIOD, RST_PERIOD, "sa_period");
    rd(OFF_PAIR_HIGH_PERIOD, RST_PERIOD, "hi_period");
    rd(OFF_STATUS, 0, "status");
    apb(1'b0, 8'h28, 16'h0000);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rdat);
    for (int i = 0; i < 3; i++) begin
      wr(CO[i], 16'hffff);
      rd(CO[i], CM[i], "ctrl_bits");
      wr(CO[i], 16'h0000);
    end
  endtask

  task automatic t_run();
    wr(OFF_SA_PERIOD, 16'h0004);
    wr(OFF_SA_COUNT, 16'h0000);
    wr(OFF_SA_CTRL, 16'h8000);
    gap(0, 50, n);
    chk("sa_gap", 5, n);
    wr(OFF_SA_CTRL, 16'h0000);
    rd(OFF_STATUS, 1, "status_set");
    wr(OFF_STATUS, 16'h0001);
    rd(OFF_STATUS, 0, "status_clr");
    apb(1'b0, OFF_SA_COUNT, 16'h0000);
    v = rdat;
    rd(OFF_SA_COUNT, v, "stopped");
    wr(OFF_SA_COUNT, 16'h0000);
    wr(OFF_SA_PERIOD, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      wr(OFF_SA_CTRL, {8'h80, 2'b00, 2'(c), 4'h0});
      gap(0, 1200, n);
      chk("prescale_gap", 2 * DIV[c], n);
      wr(OFF_SA_CTRL, 16'h0000);
    end
  endtask

  task automatic t_ext();
    wr(OFF_SA_PERIOD, 16'hffff);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_SA_COUNT, 16'h0055);
      wr(OFF_SA_CTRL, EXT_CTRL[i]);
      wr(OFF_SA_COUNT, 16'h1234);
      rd(OFF_SA_COUNT, 32'h55, "ext_write");
      slp <= (i == 1);
      edges(0, 3);
      rd(OFF_SA_COUNT, 32'h58, "ext_edges");
      slp <= 1'b0;
      wr(OFF_SA_CTRL, 16'h0000);
    end
    wr(OFF_SA_COUNT, 16'h0000);
    wr(OFF_STATUS, 16'h0007);
    wr(OFF_SA_CTRL, 16'h8040);
    repeat (20) @(posedge clk_sys_i);
    rd(OFF_SA_COUNT, 0, "gate_hold");
    edges(0, 1);
    rd(OFF_STATUS, 1, "gate_fall");
    idle <= 1'b1;
    wr(OFF_SA_CTRL, 16'ha000);
    apb(1'b0, OFF_SA_COUNT, 16'h0000);
    v = rdat;
    rd(OFF_SA_COUNT, v, "idle_stop");
    wr(OFF_SA_CTRL, 16'h8000);
    apb(1'b0, OFF_SA_COUNT, 16'h0000);
    v = rdat;
    apb(1'b0, OFF_SA_COUNT, 16'h0000);
    chk("idle_run", 1, v !== rdat);
    slp <= 1'b1;
    apb(1'b0, OFF_SA_COUNT, 16'h0000);
    v = rdat;
    rd(OFF_SA_COUNT, v, "sleep_stop");
    slp <= 1'b0;
    idle <= 1'b0;
    wr(OFF_SA_CTRL, 16'h0000);
  endtask

  task automatic t_pair();
    wr(OFF_PAIR_LOW_PERIOD, 16'h0002);
    wr(OFF_PAIR_LOW_COUNT, 16'h0000);
    wr(OFF_PAIR_CTRL, 16'h8000);
    gap(1, 50, n);
    chk("low_gap", 3, n);
    wr(OFF_PAIR_HIGH_PERIOD, 16'h0003);
    wr(OFF_PAIR_UPPER_CTRL, 16'h8010);
    gap(2, 100, n);
    chk("high_gap", 32, n);
    wr(OFF_PAIR_UPPER_CTRL, 16'h0000);
    wr(OFF_PAIR_CTRL, 16'h0000);
    wr(OFF_PAIR_LOW_PERIOD, 16'hffff);
    wr(OFF_PAIR_LOW_COUNT, 16'h0000);
    wr(OFF_PAIR_CTRL, 16'h8002);
    edges(1, 3);
    chk("low_ext", 3, lo_cnt);
    wr(OFF_PAIR_CTRL, 16'h0008);
    wr(OFF_STATUS, 16'h0007);
    wr(OFF_PAIR_LOW_COUNT, 16'hfffe);
    wr(OFF_PAIR_HIGH_COUNT, 16'h0000);
    wr(OFF_PAIR_LOW_PERIOD, 16'h0000);
    wr(OFF_PAIR_HIGH_PERIOD, 16'h0001);
    wr(OFF_PAIR_UPPER_CTRL, 16'h0032);
    wr(OFF_PAIR_CTRL, 16'h8008);
    seek(3, 20, n);
    chk("join_match", 1, n > 0);
    chk("join_high", 1, hi_cnt);
    chk("join_low", 0, lo_cnt);
    chk("join_irqs", 3'b110, ev[3:1]);
    wr(OFF_PAIR_CTRL, 16'h0000);
    rd(OFF_STATUS, 4, "join_flag");
  endtask

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_regs();
    t_run();
    t_ext();
    t_pair();
    end_sim();
  end

  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule
